// ===== tb/tb_rtcc_calendar.sv
`timescale 1ns/10ps
`default_nettype none
module tb_rtcc_calendar
  import rtcc_pkg::*;
();
  // ****************************************************************
  // Bench signals
  // ****************************************************************
  localparam int TICK = 20;
  localparam int LIMIT = 5000;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic alarm_match = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic irq_o;
  logic last_err;
  logic [31:0] d;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int i;
  int n;
  // Rollover cases: time select, date select, start, expected result, {cal ev, time ev}
  logic [1:0] tsel_t [6] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h3, 2'h0};
  logic [1:0] csel_t [6] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h1, 2'h1};
  logic [31:0] tm_t [6] = '{32'h00123059, 32'h00235959, 32'h00235959,
                            32'h00235959, 32'h00115959, 32'h00235959};
  logic [31:0] cal_t [6] = '{32'h28622420, 32'h28E22420, 32'h28E22320,
                             32'h31B29919, 32'h30440020, 32'h28820019};
  logic [31:0] ecal_t [6] = '{32'h28622420, 32'h29222420, 32'h01232320,
                              32'h01C10020, 32'h30440020, 32'h01A30019};
  logic [31:0] etm_t [6] = '{32'h00123100, 32'h00000000, 32'h00000000,
                             32'h00000000, 32'h00120000, 32'h00000000};
  logic [1:0] ev_t [6] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h1, 2'h3};

  always #5 core_clk_i = ~core_clk_i;

  rtcc_calendar #(.TICK_CYCLES(TICK)) dut (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .alarm_match_i(alarm_match),
    .irq_o(irq_o)
  );

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic fail(input string msg);
    failures = failures + 1;
    $display("[FAIL] t=%0t %s", $time, msg);
  endtask : fail

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run = tests_run + 1;
    if (got !== exp)
      fail($sformatf("%s got %h exp %h", msg, got, exp));
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    tests_run = tests_run + 1;
    if (got !== exp)
      fail($sformatf("%s got %b exp %b", msg, got, exp));
  endtask : chk_bit

  // Request holds until pready is sampled high and is released right after that edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk_i);
    penable <= 1'b1;
    @(posedge core_clk_i);
    while (pready_o !== 1'b1)
    begin
      @(posedge core_clk_i);
    end
    rd = prdata_o;
    last_err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_i);
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] x;
    apb(1'b1, a, wd, x);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    apb(1'b0, a, 32'h00000000, v);
  endtask : rd

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  always @(posedge core_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      fail("timeout");
      test_done();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd(RTCC_CAL_ADDR, d);
    chk_word(d, 32'h01210020, "cal reset");
    rd(RTCC_STAT_ADDR, d);
    chk_word(d & 32'hFFFFFFFB, 32'h00000000, "status reset");
    chk_bit(irq_o, 1'b0, "irq reset");
    $display("test reset done");
    for (i = 0; i < 6; i++)
    begin
      wr(RTCC_CTRL_ADDR, {14'h0, csel_t[i], 6'h0, tsel_t[i], 8'h03});
      n = 0;
      d = 32'h00000000;
      while (d[RTCC_ACK_BIT] !== 1'b1 && n < 20)
      begin
        rd(RTCC_STAT_ADDR, d);
        n++;
      end
      chk_bit(d[RTCC_ACK_BIT], 1'b1, "update ack");
      wr(RTCC_TIME_ADDR, tm_t[i]);
      // Unused bits are written high to show they read back zero
      wr(RTCC_CAL_ADDR, cal_t[i] | 32'hC0000080);
      wr(RTCC_CLR_ADDR, 32'h0000001F);
      wr(RTCC_CTRL_ADDR, {14'h0, csel_t[i], 6'h0, tsel_t[i], 8'h00});
      repeat (TICK + 5) @(posedge core_clk_i);
      rd(RTCC_CAL_ADDR, d);
      chk_word(d, ecal_t[i], "date rollover");
      rd(RTCC_TIME_ADDR, d);
      chk_word(d & 32'h003F7F00, etm_t[i], "time rollover");
      rd(RTCC_STAT_ADDR, d);
      chk_bit(d[RTCC_TEVT_BIT], ev_t[i][0], "time event");
      chk_bit(d[RTCC_CEVT_BIT], ev_t[i][1], "cal event");
    end
    $display("test rollover done");
    wr(RTCC_CLR_ADDR, 32'h00000001);
    rd(RTCC_STAT_ADDR, d);
    chk_bit(d[RTCC_ACK_BIT], 1'b0, "ack idle");
    wr(RTCC_CAL_ADDR, 32'h15420020);
    rd(RTCC_CAL_ADDR, d);
    chk_word(d, 32'h01A30019, "cal write locked");
    $display("test lock done");
    wr(RTCC_MASK_ADDR, 32'h00000004);
    // Clear first so the wait below lines up with a fresh tick
    wr(RTCC_CLR_ADDR, 32'h00000004);
    n = 0;
    while (irq_o !== 1'b1 && n < 40)
    begin
      n++;
      @(posedge core_clk_i);
    end
    chk_bit(irq_o, 1'b1, "irq second");
    wr(RTCC_CLR_ADDR, 32'h00000004);
    chk_bit(irq_o, 1'b0, "irq cleared");
    repeat (TICK) @(posedge core_clk_i);
    wr(RTCC_STAT_ADDR, 32'h00000000);
    rd(RTCC_STAT_ADDR, d);
    chk_bit(d[RTCC_SECEV_BIT], 1'b1, "second sticky");
    wr(RTCC_MASK_ADDR, 32'h00000000);
    chk_bit(irq_o, 1'b0, "irq masked");
    $display("test second done");
    wr(RTCC_CLR_ADDR, 32'h00000002);
    rd(RTCC_STAT_ADDR, d);
    chk_bit(d[RTCC_ALARM_BIT], 1'b0, "alarm idle");
    alarm_match <= 1'b1;
    @(posedge core_clk_i);
    alarm_match <= 1'b0;
    @(posedge core_clk_i);
    rd(RTCC_STAT_ADDR, d);
    chk_bit(d[RTCC_ALARM_BIT], 1'b1, "alarm set");
    wr(RTCC_MASK_ADDR, 32'h00000002);
    chk_bit(irq_o, 1'b1, "irq alarm");
    wr(RTCC_CLR_ADDR, 32'h00000002);
    chk_bit(irq_o, 1'b0, "irq alarm cleared");
    $display("test alarm done");
    rd(32'hFFFFFDC0, d);
    chk_bit(last_err, 1'b1, "unmapped error");
    chk_word(d, 32'h00000000, "unmapped data");
    $display("test unmapped done");
    test_done();
  end
endmodule : tb_rtcc_calendar
`default_nettype wire

// ===== verilog/rtcc_calendar.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rtcc_calendar
  import rtcc_pkg::*;
#(
  parameter int TICK_CYCLES = RTCC_TICK_CYCLES
)
(
  input wire logic core_clk_i, // System clock
  input wire logic rst_i, // Async reset, high
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [31:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error on unmapped address
  input wire logic alarm_match_i, // Alarm match pulse
  output logic irq_o // Level interrupt
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [26:0] presc;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] century_field;
    logic [7:0] year;
    logic [7:0] month;
    logic [2:0] dow;
    logic [7:0] date;
    logic upd_tim;
    logic upd_cal;
    logic [1:0] tsel;
    logic [1:0] csel;
    logic [4:0] stat;
    logic [4:0] mask;
    logic [31:0] rdata;
  } rtcc_state_t;

  rtcc_state_t q;
  rtcc_state_t d;

  logic tick;
  logic sec_roll;
  logic min_roll;
  logic hour_roll;
  logic noon;
  logic day_roll;
  logic week_chg;
  logic month_roll;
  logic year_roll;
  logic time_ev;
  logic cal_ev;
  logic [4:0] ev_set;
  logic [4:0] clr;
  logic wr_acc;
  logic mapped;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
    begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end
    else
    begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  // Leap year when the BCD year is a multiple of four; year 00 only in century 20
  function automatic logic is_leap(input logic [7:0] yr, input logic [7:0] ce);
    logic div4;
    div4 = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (yr == 8'h00)
    begin
      is_leap = (ce == 8'h20);
    end
    else
    begin
      is_leap = div4;
    end
  endfunction : is_leap

  function automatic logic [7:0] month_len(input logic [7:0] mo, input logic lp);
    case (mo)
      8'h02: month_len = lp ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  endfunction : month_len

  function automatic logic is_mapped(input logic [31:0] a);
    is_mapped = (a == RTCC_CTRL_ADDR) || (a == RTCC_TIME_ADDR) || (a == RTCC_CAL_ADDR)
             || (a == RTCC_STAT_ADDR) || (a == RTCC_CLR_ADDR) || (a == RTCC_MASK_ADDR);
  endfunction : is_mapped

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    d = q;
    tick = (q.presc == 27'(TICK_CYCLES - 1));
    d.presc = tick ? 27'h0000000 : q.presc + 27'h0000001;

    // Time counting stops while software holds the time update request
    sec_roll = tick && !q.upd_tim && (q.sec == 8'h59);
    min_roll = sec_roll && (q.min == 8'h59);
    hour_roll = min_roll;
    noon = min_roll && (q.hour == 8'h11);
    day_roll = min_roll && (q.hour == 8'h23);
    if (tick && !q.upd_tim)
    begin
      d.sec = sec_roll ? 8'h00 : bcd_inc(q.sec);
      if (sec_roll)
      begin
        d.min = min_roll ? 8'h00 : bcd_inc(q.min);
      end
      if (min_roll)
      begin
        d.hour = day_roll ? 8'h00 : bcd_inc(q.hour);
      end
    end

    // Day-of-week runs on its own and never steers the date
    week_chg = day_roll && !q.upd_cal && (q.dow == 3'h7);
    month_roll = day_roll && !q.upd_cal
              && (q.date == month_len(q.month, is_leap(q.year, q.century_field)));
    year_roll = month_roll && (q.month == 8'h12);
    if (day_roll && !q.upd_cal)
    begin
      d.dow = week_chg ? 3'h1 : q.dow + 3'h1;
      d.date = month_roll ? 8'h01 : bcd_inc(q.date);
      if (month_roll)
      begin
        d.month = year_roll ? 8'h01 : bcd_inc(q.month);
      end
      if (year_roll)
      begin
        d.year = (q.year == 8'h99) ? 8'h00 : bcd_inc(q.year);
        if (q.year == 8'h99)
        begin
          d.century_field = bcd_inc(q.century_field);
        end
      end
    end

    // Event selection
    unique case (q.tsel)
      RTCC_TSEL_MINUTE: time_ev = sec_roll;
      RTCC_TSEL_HOUR: time_ev = hour_roll;
      RTCC_TSEL_MIDNIGHT: time_ev = day_roll;
      RTCC_TSEL_NOON: time_ev = noon;
    endcase
    unique case (q.csel)
      RTCC_CSEL_WEEK: cal_ev = week_chg;
      RTCC_CSEL_MONTH: cal_ev = month_roll;
      RTCC_CSEL_YEAR: cal_ev = year_roll;
      default: cal_ev = 1'b0;
    endcase

    ev_set = 5'h00;
    ev_set[RTCC_ACK_BIT] = tick && (q.upd_tim || q.upd_cal);
    ev_set[RTCC_ALARM_BIT] = alarm_match_i;
    ev_set[RTCC_SECEV_BIT] = tick;
    ev_set[RTCC_TEVT_BIT] = time_ev;
    ev_set[RTCC_CEVT_BIT] = cal_ev;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    mapped = is_mapped(paddr_i);
    wr_acc = psel_i && penable_i && pwrite_i && mapped;
    clr = 5'h00;
    if (wr_acc)
    begin
      unique case (paddr_i)
        RTCC_CTRL_ADDR:
        begin
          d.upd_tim = pwdata_i[RTCC_UPDTIM_BIT];
          d.upd_cal = pwdata_i[RTCC_UPDCAL_BIT];
          d.tsel = pwdata_i[RTCC_TSEL_LSB +: 2];
          d.csel = pwdata_i[RTCC_CSEL_LSB +: 2];
        end
        RTCC_TIME_ADDR:
        begin
          if (q.upd_tim && q.stat[RTCC_ACK_BIT])
          begin
            d.sec = {1'b0, pwdata_i[RTCC_SEC_LSB +: 7]};
            d.min = {1'b0, pwdata_i[RTCC_MIN_LSB +: 7]};
            d.hour = {2'b00, pwdata_i[RTCC_HOUR_LSB +: 6]};
          end
        end
        RTCC_CAL_ADDR:
        begin
          if (q.upd_cal && q.stat[RTCC_ACK_BIT])
          begin
            d.century_field = {1'b0, pwdata_i[RTCC_CENTURY_FIELD_LSB +: 7]};
            d.year = pwdata_i[RTCC_YEAR_LSB +: 8];
            d.month = {3'b000, pwdata_i[RTCC_MONTH_LSB +: 5]};
            d.dow = pwdata_i[RTCC_DOW_LSB +: 3];
            d.date = {2'b00, pwdata_i[RTCC_DATE_LSB +: 6]};
          end
        end
        RTCC_CLR_ADDR: clr = pwdata_i[4:0];
        RTCC_MASK_ADDR: d.mask = pwdata_i[4:0];
        default: clr = 5'h00; // Status word ignores writes
      endcase
    end

    // An event in the clearing cycle survives the clear
    d.stat = (q.stat & ~clr) | ev_set;

    // Read data is latched in the setup phase, so the access never waits
    if (psel_i && !penable_i && !pwrite_i)
    begin
      d.rdata = 32'h00000000;
      unique case (paddr_i)
        RTCC_CTRL_ADDR:
        begin
          d.rdata[RTCC_UPDTIM_BIT] = q.upd_tim;
          d.rdata[RTCC_UPDCAL_BIT] = q.upd_cal;
          d.rdata[RTCC_TSEL_LSB +: 2] = q.tsel;
          d.rdata[RTCC_CSEL_LSB +: 2] = q.csel;
        end
        RTCC_TIME_ADDR:
        begin
          d.rdata[RTCC_SEC_LSB +: 7] = q.sec[6:0];
          d.rdata[RTCC_MIN_LSB +: 7] = q.min[6:0];
          d.rdata[RTCC_HOUR_LSB +: 6] = q.hour[5:0];
        end
        RTCC_CAL_ADDR:
        begin
          // Bits 31:30 and 7 stay zero
          d.rdata[RTCC_CENTURY_FIELD_LSB +: 7] = q.century_field[6:0];
          d.rdata[RTCC_YEAR_LSB +: 8] = q.year;
          d.rdata[RTCC_MONTH_LSB +: 5] = q.month[4:0];
          d.rdata[RTCC_DOW_LSB +: 3] = q.dow;
          d.rdata[RTCC_DATE_LSB +: 6] = q.date[5:0];
        end
        RTCC_STAT_ADDR: d.rdata[4:0] = q.stat;
        RTCC_MASK_ADDR: d.rdata[4:0] = q.mask;
        default: d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.century_field <= RTCC_CENTURY_FIELD_RST;
      q.year <= RTCC_YEAR_RST;
      q.month <= RTCC_MONTH_RST;
      q.dow <= RTCC_DOW_RST;
      q.date <= RTCC_DATE_RST;
      q.mask <= RTCC_MASK_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata_o = q.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign irq_o = |(q.stat & q.mask);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_cal_unused;
    (psel_i && !penable_i && !pwrite_i && paddr_i == RTCC_CAL_ADDR)
      |=> (prdata_o[31:30] == 2'b00 && prdata_o[7] == 1'b0);
  endproperty
  a_cal_unused: assert property (p_cal_unused)
    else $error("calendar unused bits not zero");

  property p_sec_flag;
    (tick && !(wr_acc && paddr_i == RTCC_CLR_ADDR)) |=> q.stat[RTCC_SECEV_BIT] [*1];
  endproperty
  a_sec_flag: assert property (p_sec_flag)
    else $error("second event flag not set");

  property p_time_minute;
    (q.tsel == RTCC_TSEL_MINUTE && sec_roll) |=> q.stat[RTCC_TEVT_BIT] && q.sec == 8'h00;
  endproperty
  a_time_minute: assert property (p_time_minute)
    else $error("minute time event missed");

  property p_noon;
    (q.tsel == RTCC_TSEL_NOON && noon) |=> (q.hour == 8'h12 && q.stat[RTCC_TEVT_BIT]);
  endproperty
  a_noon: assert property (p_noon)
    else $error("noon time event missed");

  property p_week;
    (q.csel == RTCC_CSEL_WEEK && week_chg) |=> (q.dow == 3'h1 && q.stat[RTCC_CEVT_BIT]);
  endproperty
  a_week: assert property (p_week)
    else $error("week calendar event missed");

  property p_ack_cause;
    $rose(q.stat[RTCC_ACK_BIT]) |-> $past(q.upd_tim || q.upd_cal);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("update acknowledge without request");

  property p_alarm;
    alarm_match_i |=> q.stat[RTCC_ALARM_BIT];
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm flag not set");

  property p_dow_step;
    (day_roll && !q.upd_cal && q.dow != 3'h7) |=> q.dow == $past(q.dow) + 3'h1;
  endproperty
  a_dow_step: assert property (p_dow_step)
    else $error("weekday did not advance");

  property p_month_tens;
    (month_roll && q.month == 8'h09) |=> (q.month == 8'h10 && q.date == 8'h01);
  endproperty
  a_month_tens: assert property (p_month_tens)
    else $error("BCD month carry wrong");

  property p_feb_leap;
    (day_roll && !q.upd_cal && q.month == 8'h02 && q.date == 8'h28
      && (q.year == 8'h24 || (q.year == 8'h00 && q.century_field == 8'h20))) |=> q.date == 8'h29;
  endproperty
  a_feb_leap: assert property (p_feb_leap)
    else $error("leap day skipped");

  property p_stat_ro;
    (wr_acc && paddr_i == RTCC_STAT_ADDR && ev_set == 5'h00) |=> $stable(q.stat);
  endproperty
  a_stat_ro: assert property (p_stat_ro)
    else $error("status changed on write");

  property p_irq;
    (q.stat[RTCC_SECEV_BIT] && q.mask[RTCC_SECEV_BIT]) |-> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");

  property p_hour_ev;
    (q.tsel == RTCC_TSEL_HOUR && hour_roll) |=> (q.min == 8'h00 && q.stat[RTCC_TEVT_BIT]);
  endproperty
  a_hour_ev: assert property (p_hour_ev)
    else $error("hour time event missed");

  // Locked writes must not disturb a running date
  property p_cal_locked;
    (wr_acc && paddr_i == RTCC_CAL_ADDR && !q.upd_cal && !tick)
      |=> ($stable(q.date) && $stable(q.month) && $stable(q.year));
  endproperty
  a_cal_locked: assert property (p_cal_locked)
    else $error("calendar written without acknowledge");

endmodule : rtcc_calendar
`default_nettype wire

// ===== verilog/rtcc_pkg.sv
`default_nettype none
package rtcc_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [31:0] RTCC_CTRL_ADDR = 32'hFFFFFDB0;
  localparam logic [31:0] RTCC_TIME_ADDR = 32'hFFFFFDB4;
  localparam logic [31:0] RTCC_CAL_ADDR = 32'h0FFFFDBC;
  localparam logic [31:0] RTCC_STAT_ADDR = 32'hFFFFFDC8;
  localparam logic [31:0] RTCC_CLR_ADDR = 32'hFFFFFDCC;
  localparam logic [31:0] RTCC_MASK_ADDR = 32'hFFFFFDD0;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RTCC_CENTURY_FIELD_LSB = 0;
  localparam int RTCC_YEAR_LSB = 8;
  localparam int RTCC_MONTH_LSB = 16;
  localparam int RTCC_DOW_LSB = 21;
  localparam int RTCC_DATE_LSB = 24;
  localparam int RTCC_SEC_LSB = 0;
  localparam int RTCC_MIN_LSB = 8;
  localparam int RTCC_HOUR_LSB = 16;
  localparam int RTCC_UPDTIM_BIT = 0;
  localparam int RTCC_UPDCAL_BIT = 1;
  localparam int RTCC_TSEL_LSB = 8;
  localparam int RTCC_CSEL_LSB = 16;
  localparam int RTCC_ACK_BIT = 0;
  localparam int RTCC_ALARM_BIT = 1;
  localparam int RTCC_SECEV_BIT = 2;
  localparam int RTCC_TEVT_BIT = 3;
  localparam int RTCC_CEVT_BIT = 4;

  // ****************************************************************
  // Event select codes
  // ****************************************************************
  localparam logic [1:0] RTCC_TSEL_MINUTE = 2'h0;
  localparam logic [1:0] RTCC_TSEL_HOUR = 2'h1;
  localparam logic [1:0] RTCC_TSEL_MIDNIGHT = 2'h2;
  localparam logic [1:0] RTCC_TSEL_NOON = 2'h3;
  localparam logic [1:0] RTCC_CSEL_WEEK = 2'h0;
  localparam logic [1:0] RTCC_CSEL_MONTH = 2'h1;
  localparam logic [1:0] RTCC_CSEL_YEAR = 2'h2;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [7:0] RTCC_CENTURY_FIELD_RST = 8'h20;
  localparam logic [7:0] RTCC_YEAR_RST = 8'h00;
  localparam logic [7:0] RTCC_MONTH_RST = 8'h01;
  localparam logic [2:0] RTCC_DOW_RST = 3'h1;
  localparam logic [7:0] RTCC_DATE_RST = 8'h01;
  localparam logic [4:0] RTCC_MASK_RST = 5'h00;
  localparam int RTCC_SEC_PERIOD_NS = 1000000000;
  localparam int RTCC_CLK_PERIOD_NS = 10;
  localparam int RTCC_TICK_CYCLES = RTCC_SEC_PERIOD_NS / RTCC_CLK_PERIOD_NS;

endpackage : rtcc_pkg
`default_nettype wire
